// ### hdl/mmhc_misc_control.sv
// Miscellaneous memory and host control register with its consumers.
// Assumes an Avalon-MM master on clk, and memory and host logic on clk.
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/100ps
`include "mmhc_cfg.svh"
module mmhc_misc_control import mmhc_pkg::*; #(
  parameter logic [3:0] IOQ_DEPTH = `MMHC_IOQ_DEPTH
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  // Avalon-MM slave, byte addressed
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Memory controller side
  input  wire logic        rd_req,
  input  wire logic        wr_req,
  input  wire logic        cpc_req,
  output logic             rd_grant,
  output logic             wr_grant,
  output logic             cpc_allow,
  output logic             transmit_bypass,
  output logic             memory_freq_133,
  // Host transaction unit side
  input  wire logic [3:0]  ioq_level,
  input  wire logic [3:0]  ioq_retiring,
  output logic             block_new_requests,
  // Graphics side
  output logic             graphics_mode,
  output logic             gtt_window_32mb
);

  localparam logic [9:0] MISC_ADDR   = {`MMHC_MISC_IDX, 2'b00};
  localparam logic [9:0] HUBCFG_ADDR = {`MMHC_HUBCFG_IDX, 2'b00};
  localparam logic [9:0] APCTL_ADDR  = {`MMHC_APCTL_IDX, 2'b00};

  mmhc_state_t s_r;
  mmhc_state_t s_nxt;

  logic [3:0]  rd_limit;
  logic [3:0]  wr_limit;
  logic        sel_misc;
  logic        sel_hub;
  logic        sel_ap;
  logic        wr_take;
  logic [15:0] misc_wmask;
  logic [15:0] misc_lanes;
  logic [15:0] misc_next;
  logic        freq_wr_ok;
  logic        cpc_allow_r;

  // Slot limit for the read throttle field
  function automatic logic [3:0] rd_lim(input logic [1:0] f);
    logic [3:0] l;
    unique case (f)
      2'h0: l = `MMHC_RD_LIM_0;
      2'h1: l = `MMHC_RD_LIM_1;
      2'h2: l = `MMHC_RD_LIM_2;
      2'h3: l = `MMHC_RD_LIM_3;
    endcase
    return l;
  endfunction : rd_lim

  // Slot limit for the write throttle field
  function automatic logic [3:0] wr_lim(input logic [1:0] f);
    logic [3:0] l;
    unique case (f)
      2'h0: l = `MMHC_WR_LIM_0;
      2'h1: l = `MMHC_WR_LIM_1;
      2'h2: l = `MMHC_WR_LIM_2;
      2'h3: l = `MMHC_WR_LIM_3;
    endcase
    return l;
  endfunction : wr_lim

  // Byte lanes of the 16-bit register that the access enables
  function automatic logic [15:0] lane_mask(input logic [3:0] be);
    return {{8{be[1]}}, {8{be[0]}}};
  endfunction : lane_mask

  // Address decode
  always_comb begin
    sel_misc = (avs_address == MISC_ADDR);
    sel_hub  = (avs_address == HUBCFG_ADDR);
    sel_ap   = (avs_address == APCTL_ADDR);
  end

  // A write takes effect only in the cycle waitrequest is low
  always_comb begin
    wr_take = (s_r.fsm == MMHC_ACK) && avs_write;
  end

  // Throttle limits from the current fields
  always_comb begin
    rd_limit = rd_lim(s_r.misc[`MMHC_F_RD_HI:`MMHC_F_RD_LO]);
    wr_limit = wr_lim(s_r.misc[`MMHC_F_WR_HI:`MMHC_F_WR_LO]);
  end

  // Writable bits of misc_control for this access
  always_comb begin
    misc_wmask = `MMHC_MISC_WMASK;
    if (s_r.misc[`MMHC_B_LOCK]) begin
      misc_wmask = misc_wmask & ~`MMHC_LOCK_MASK;
    end
    misc_lanes = misc_wmask & lane_mask(avs_byteenable);
  end

  // Merge of old value and write data
  always_comb begin
    misc_next = s_r.misc;
    if (wr_take && sel_misc) begin
      misc_next = (s_r.misc & ~misc_lanes) | (avs_writedata[15:0] & misc_lanes);
    end
    // Lock is sticky: a set bit survives any write
    misc_next[`MMHC_B_LOCK] = misc_next[`MMHC_B_LOCK] | s_r.misc[`MMHC_B_LOCK];
    misc_next = misc_next & `MMHC_MISC_WMASK;
  end

  // Frequency select may change in port mode, or in graphics mode with bit15
  always_comb begin
    freq_wr_ok = !s_r.gfx || s_r.misc[`MMHC_B_PC133];
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.misc = misc_next;

    // Own register holding the memory frequency select
    if (wr_take && sel_hub && avs_byteenable[0] && freq_wr_ok) begin
      s_nxt.freq_sel = avs_writedata[`MMHC_B_FREQ];
    end
    // Hard zero while graphics mode keeps memory at 100 MHz
    if (s_r.gfx && !s_r.misc[`MMHC_B_PC133]) begin
      s_nxt.freq_sel = 1'b0;
    end

    // Own register holding the aperture control mode bit
    if (wr_take && sel_ap && avs_byteenable[0]) begin
      s_nxt.gfx = avs_writedata[`MMHC_B_APCTL];
    end

    // Transmit stage: forced bypass, else bypass only at 100 MHz
    s_nxt.bypass = s_r.misc[`MMHC_B_BYPASS] || !s_r.freq_sel;

    // Command-per-clock mask
    s_nxt.cpc = s_r.misc[`MMHC_B_CPC];

    // Lookahead enable for the host unit
    s_nxt.bnr_la = s_r.misc[`MMHC_B_BNR];

    // Window size only means something in graphics mode
    s_nxt.gtt32 = s_r.gfx && s_r.misc[`MMHC_B_GTT];

    // Bus handshake
    unique case (s_r.fsm)
      MMHC_IDLE: begin
        s_nxt.wait_r = 1'b1;
        if (avs_read || avs_write) begin
          s_nxt.fsm    = MMHC_ACK;
          s_nxt.wait_r = 1'b0;
          s_nxt.rdata  = 32'h0000_0000;
          // Unmapped addresses read zero and ignore writes
          if (sel_misc) begin
            s_nxt.rdata[15:0] = s_r.misc;
          end else if (sel_hub) begin
            s_nxt.rdata[`MMHC_B_FREQ] = s_r.freq_sel;
          end else if (sel_ap) begin
            s_nxt.rdata[`MMHC_B_APCTL] = s_r.gfx;
          end
        end
      end
      MMHC_ACK: begin
        s_nxt.fsm    = MMHC_IDLE;
        s_nxt.wait_r = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_r.fsm      <= MMHC_IDLE;
      s_r.wait_r   <= 1'b1;
      s_r.rdata    <= 32'h0000_0000;
      s_r.misc     <= `MMHC_MISC_RST;
      s_r.freq_sel <= `MMHC_HUBCFG_RST;
      s_r.gfx      <= `MMHC_APCTL_RST;
      s_r.bypass   <= 1'b1;
      s_r.cpc      <= 1'b0;
      s_r.bnr_la   <= 1'b0;
      s_r.gtt32    <= 1'b0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  // Command-per-clock grant; registered so the port comes from a flop
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cpc_allow_r <= 1'b0;
    end else if (ce) begin
      cpc_allow_r <= cpc_req && !s_r.cpc;
    end
  end

  mmhc_throttle #(
    .SLOTS (`MMHC_THR_SLOTS)
  ) u_rd_thr (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .limit   (rd_limit),
    .req     (rd_req),
    .grant   (rd_grant)
  );

  mmhc_throttle #(
    .SLOTS (`MMHC_THR_SLOTS)
  ) u_wr_thr (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .limit   (wr_limit),
    .req     (wr_req),
    .grant   (wr_grant)
  );

  mmhc_bnr #(
    .DEPTH (IOQ_DEPTH)
  ) u_bnr (
    .clk                (clk),
    .sys_rst            (sys_rst),
    .ce                 (ce),
    .lookahead          (s_r.bnr_la),
    .ioq_level          (ioq_level),
    .retiring           (ioq_retiring),
    .block_new_requests (block_new_requests)
  );

  assign avs_readdata    = s_r.rdata;
  assign avs_waitrequest = s_r.wait_r;
  assign cpc_allow       = cpc_allow_r;
  assign transmit_bypass = s_r.bypass;
  assign memory_freq_133 = s_r.freq_sel;
  assign graphics_mode   = s_r.gfx;
  assign gtt_window_32mb = s_r.gtt32;

endmodule : mmhc_misc_control

// ### include/mmhc_cfg.svh
// Offsets, field positions, reset values and limits of the miscellaneous
// memory and host control block. Definitions only.
`ifndef MMHC_CFG_SVH
`define MMHC_CFG_SVH

// Register indices; byte address is the index times four
`define MMHC_MISC_IDX    8'h72
`define MMHC_HUBCFG_IDX  8'h50
`define MMHC_APCTL_IDX   8'h51

// Reset values
`define MMHC_MISC_RST    16'h0000
`define MMHC_HUBCFG_RST  1'h0
`define MMHC_APCTL_RST   1'h0

// Field positions of misc_control
`define MMHC_B_PC133     15
`define MMHC_B_BYPASS    13
`define MMHC_B_CPC       11
`define MMHC_F_RD_HI     7
`define MMHC_F_RD_LO     6
`define MMHC_F_WR_HI     5
`define MMHC_F_WR_LO     4
`define MMHC_B_LOCK      3
`define MMHC_B_BNR       1
`define MMHC_B_GTT       0

// Writable bits, and bits frozen by the lock
`define MMHC_MISC_WMASK  16'hA8FB
`define MMHC_LOCK_MASK   16'h00F8

// Own registers: field positions
`define MMHC_B_FREQ      2
`define MMHC_B_APCTL     0

// Throttle window and slot limits (8 slots = 800 MB/s)
`define MMHC_THR_SLOTS   4'h8
`define MMHC_RD_LIM_0    4'h8
`define MMHC_RD_LIM_1    4'h7
`define MMHC_RD_LIM_2    4'h6
`define MMHC_RD_LIM_3    4'h5
`define MMHC_WR_LIM_0    4'h8
`define MMHC_WR_LIM_1    4'h5
`define MMHC_WR_LIM_2    4'h4
`define MMHC_WR_LIM_3    4'h3

// Default in-order queue depth
`define MMHC_IOQ_DEPTH   4'h8

`endif

// ### include/mmhc_pkg.sv
// Types of the miscellaneous memory and host control block.
// Assumes mmhc_cfg.svh is on the include path.
package mmhc_pkg;

  typedef enum logic {
    MMHC_IDLE,
    MMHC_ACK
  } mmhc_fsm_t;

  typedef struct packed {
    mmhc_fsm_t   fsm;
    logic        wait_r;
    logic [31:0] rdata;
    logic [15:0] misc;
    logic        freq_sel;
    logic        gfx;
    logic        bypass;
    logic        cpc;
    logic        bnr_la;
    logic        gtt32;
  } mmhc_state_t;

  typedef struct packed {
    logic [3:0] slot;
    logic       grant;
  } mmhc_thr_t;

  typedef struct packed {
    logic       bnr;
  } mmhc_bnr_t;

endpackage : mmhc_pkg

// ### hdl/mmhc_throttle.sv
// Bandwidth throttle: grants at most LIMIT of every SLOTS cycles.
// Assumes request and limit come from logic on the same clock.
`timescale 1ns/100ps
`include "mmhc_cfg.svh"
module mmhc_throttle import mmhc_pkg::*; #(
  parameter logic [3:0] SLOTS = `MMHC_THR_SLOTS
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       ce,
  input  wire logic [3:0] limit,
  input  wire logic       req,
  output logic            grant
);

  mmhc_thr_t s_r;
  mmhc_thr_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.slot = (s_r.slot == SLOTS - 4'h1) ? 4'h0 : s_r.slot + 4'h1;
    // Slots beyond the limit stay idle, capping the average rate
    s_nxt.grant = req && (s_r.slot < limit);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign grant = s_r.grant;

endmodule : mmhc_throttle

// ### hdl/mmhc_bnr.sv
// Block-new-requests generator for the host transaction unit.
// Assumes queue level and retiring count come from the same clock.
`timescale 1ns/100ps
`include "mmhc_cfg.svh"
module mmhc_bnr import mmhc_pkg::*; #(
  parameter logic [3:0] DEPTH = `MMHC_IOQ_DEPTH
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       ce,
  input  wire logic       lookahead,
  input  wire logic [3:0] ioq_level,
  input  wire logic [3:0] retiring,
  output logic            block_new_requests
);

  mmhc_bnr_t s_r;
  mmhc_bnr_t s_nxt;
  logic [3:0] eff_level;

  always_comb begin
    s_nxt = s_r;
    // Lookahead leaves out entries whose data is already leaving
    eff_level = ioq_level;
    if (lookahead) begin
      eff_level = (retiring > ioq_level) ? 4'h0 : ioq_level - retiring;
    end
    s_nxt.bnr = (eff_level >= DEPTH - 4'h1);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign block_new_requests = s_r.bnr;

endmodule : mmhc_bnr

// ### test/mmhc_misc_control_monitor.sv
// Port checker for the misc control block.
// Assumes binding into mmhc_misc_control, one clock clk.
`timescale 1ns/100ps
module mmhc_monitor import mmhc_pkg::*; #(
  parameter logic [3:0] IOQ_DEPTH = 4'h8
) (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic [9:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        rd_req,
  input wire logic        wr_req,
  input wire logic        cpc_req,
  input wire logic        rd_grant,
  input wire logic        wr_grant,
  input wire logic        cpc_allow,
  input wire logic        transmit_bypass,
  input wire logic        memory_freq_133,
  input wire logic [3:0]  ioq_level,
  input wire logic        block_new_requests,
  input wire logic        graphics_mode,
  input wire logic        gtt_window_32mb
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_rst;
    $past(sys_rst) |-> avs_waitrequest && avs_readdata == 32'h0 && transmit_bypass
      && !memory_freq_133 && !graphics_mode && !rd_grant && !wr_grant && !cpc_allow;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_wait_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
  property p_wait_cause;
    !avs_waitrequest |-> $past(avs_read || avs_write);
  endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("answer without request");
  property p_upper;
    !avs_waitrequest && avs_read |-> avs_readdata[31:16] == 16'h0000;
  endproperty
  a_upper: assert property (p_upper) else $error("upper half not zero");
  property p_resv;
    !avs_waitrequest && avs_read && avs_address == 10'h1C8 |-> (avs_readdata & 32'h5704) == 0;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bit set");
  property p_cpc;
    cpc_allow |-> $past(cpc_req);
  endproperty
  a_cpc: assert property (p_cpc) else $error("cpc without request");
  property p_rd;
    rd_grant |-> $past(rd_req);
  endproperty
  a_rd: assert property (p_rd) else $error("read grant without request");
  property p_wr;
    wr_grant |-> $past(wr_req);
  endproperty
  a_wr: assert property (p_wr) else $error("write grant without request");
  property p_byp;
    !$past(memory_freq_133) |-> transmit_bypass;
  endproperty
  a_byp: assert property (p_byp) else $error("no bypass at low speed");
  property p_gtt;
    gtt_window_32mb |-> $past(graphics_mode);
  endproperty
  a_gtt: assert property (p_gtt) else $error("window select outside graphics");
  property p_bnr;
    block_new_requests |-> $past(ioq_level) >= IOQ_DEPTH - 4'h1;
  endproperty
  a_bnr: assert property (p_bnr) else $error("block raised with shallow queue");
endmodule : mmhc_monitor
bind mmhc_misc_control mmhc_monitor #(.IOQ_DEPTH(IOQ_DEPTH)) u_mmhc_monitor (.*);

// ### test/tb_top.sv
// Self-checking bench for the misc control register block.
// Assumes the monitor is bound in; ce and byte enables held on.
`timescale 1ns/100ps
module tb_top import mmhc_pkg::*;;
  localparam logic [9:0] MISC = 10'h1C8;
  localparam logic [9:0] HUB  = 10'h140;
  localparam logic [9:0] APC  = 10'h144;
  localparam logic [9:0] UNM  = 10'h3FC;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [9:0]  avs_address = 10'h000;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        rd_req = 1'b0;
  logic        wr_req = 1'b0;
  logic        cpc_req = 1'b0;
  logic [3:0]  ioq_level = 4'h0;
  logic [3:0]  ioq_retiring = 4'h0;
  logic        rd_grant, wr_grant, cpc_allow, transmit_bypass, memory_freq_133;
  logic        block_new_requests, graphics_mode, gtt_window_32mb;
  logic [31:0] d;
  logic [31:0] exp_q[$];
  logic [3:0]  rl[4] = '{4'h8, 4'h7, 4'h6, 4'h5};
  logic [3:0]  wl[4] = '{4'h8, 4'h5, 4'h4, 4'h3};
  // Rows: lookahead, level, retiring, expected block (depth 8)
  logic [9:0]  bt[6] = '{10'h0E7, 10'h0C0, 10'h2E6, 10'h325, 10'h24A, 10'h2E1};
  int          num_errors = 0;
  int          checks = 0;
  mmhc_misc_control u_mmhc_misc_control (
    .clk(clk), .sys_rst(sys_rst), .ce(1'b1), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rd_req(rd_req), .wr_req(wr_req), .cpc_req(cpc_req), .rd_grant(rd_grant),
    .wr_grant(wr_grant), .cpc_allow(cpc_allow), .transmit_bypass(transmit_bypass),
    .memory_freq_133(memory_freq_133), .ioq_level(ioq_level), .ioq_retiring(ioq_retiring),
    .block_new_requests(block_new_requests), .graphics_mode(graphics_mode),
    .gtt_window_32mb(gtt_window_32mb));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic conclude();
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic chk(input logic got, input logic exp);
    cmp({31'h0, got}, {31'h0, exp});
  endtask : chk
  // Request held until waitrequest is seen low, then released
  task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] v);
    int n = 0;
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= v;
    avs_write     <= wr;
    avs_read      <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) begin
      num_errors++;
      conclude();
    end
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus
  task automatic wr(input logic [9:0] a, input logic [31:0] v);
    bus(1'b1, a, v);
  endtask : wr
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd
  // Field outputs lag the commit by up to two cycles
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask : settle
  task automatic count(input logic [3:0] r_lim, input logic [3:0] w_lim);
    logic [7:0] r = 8'h00;
    logic [7:0] w = 8'h00;
    repeat (16) begin
      @(posedge clk);
      r = r + {7'h0, rd_grant === 1'b1};
      w = w + {7'h0, wr_grant === 1'b1};
    end
    cmp({24'h0, r}, {27'h0, r_lim, 1'b0});
    cmp({24'h0, w}, {27'h0, w_lim, 1'b0});
  endtask : count
  always @(posedge clk) begin
    if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0)
      cmp(avs_readdata, exp_q.pop_front());
  end
  initial begin
    void'($urandom(32'h22E0));
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd(MISC, 32'h0);
    wr(UNM, 32'hFFFFFFFF);
    rd(UNM, 32'h0);
    for (int i = 0; i < 4; i++) begin
      d = $urandom & 32'hFFFFFFF7;
      wr(MISC, d);
      rd(MISC, d & 32'h0000A8FB);
    end
    // Write throttle at the 100 MHz setting
    wr(MISC, 32'h0010);
    cpc_req <= 1'b1;
    settle();
    chk(transmit_bypass, 1'b1);
    chk(cpc_allow, 1'b1);
    // Mask and throttle set before moving to 133 MHz
    wr(MISC, 32'h0820);
    wr(HUB, 32'h4);
    rd(HUB, 32'h4);
    settle();
    chk(memory_freq_133, 1'b1);
    chk(transmit_bypass, 1'b0);
    chk(cpc_allow, 1'b0);
    wr(MISC, 32'h2820);
    settle();
    chk(transmit_bypass, 1'b1);
    // Bit15 set ahead of the mode switch, cleared after it
    wr(MISC, 32'hA820);
    wr(APC, 32'h1);
    wr(MISC, 32'h0);
    settle();
    chk(graphics_mode, 1'b1);
    chk(memory_freq_133, 1'b0);
    wr(HUB, 32'h4);
    rd(HUB, 32'h0);
    wr(MISC, 32'h8001);
    wr(HUB, 32'h4);
    settle();
    chk(memory_freq_133, 1'b1);
    chk(gtt_window_32mb, 1'b1);
    wr(APC, 32'h0);
    settle();
    chk(gtt_window_32mb, 1'b0);
    rd_req <= 1'b1;
    wr_req <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(MISC, {24'h0, i[1:0], i[1:0], 4'h0});
      settle();
      count(rl[i], wl[i]);
    end
    foreach (bt[i]) begin
      wr(MISC, {30'h0, bt[i][9], 1'b0});
      ioq_level    <= bt[i][8:5];
      ioq_retiring <= bt[i][4:1];
      settle();
      chk(block_new_requests, bt[i][0]);
    end
    // Lock and locked bits written together, then frozen
    wr(MISC, 32'h00F8);
    rd(MISC, 32'h00F8);
    wr(MISC, 32'hA803);
    rd(MISC, 32'hA8FB);
    wr(MISC, 32'h0);
    rd(MISC, 32'h00F8);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd(MISC, 32'h0);
    repeat (2) @(posedge clk);
    cmp(32'(exp_q.size()), 32'h0);
    conclude();
  end
endmodule : tb_top
